/* File: hdl/ppt_pkg.sv */
`default_nettype none
package ppt_pkg;
    localparam int CLK_PERIOD_NS = 4;
    localparam int SCALAR_HIGH_NS = 18000;
    localparam int SCALAR_PERIOD_NS = 36000;
    localparam int SCALAR_HIGH_CYC = (SCALAR_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCALAR_PERIOD_CYC = (SCALAR_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NARROW_PW_NS = 1000;
    localparam int NARROW_PW_CYC = (NARROW_PW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] REG_WIDTH = 5'h04;
    localparam logic [ADDR_W-1:0] REG_PERIOD = 5'h08;
    localparam logic [ADDR_W-1:0] REG_DELAY = 5'h0c;
    localparam logic [ADDR_W-1:0] REG_GAP = 5'h10;
    localparam logic [ADDR_W-1:0] REG_BBLEN = 5'h14;
    localparam logic [ADDR_W-1:0] REG_BBCMD = 5'h18;
    localparam logic [ADDR_W-1:0] REG_STATUS = 5'h1c;

    localparam int CTRL_PM_EN = 0;
    localparam int CTRL_SRC_LSB = 1;
    localparam int CTRL_BB_EN = 4;
    localparam int CTRL_STYLE_LSB = 5;
    localparam int CTRL_BBSRC_LSB = 7;
    localparam int CTRL_POL = 9;
    localparam int CMD_BUS_TRIG = 0;

    localparam int WIDTH_RST = 16'h0064;
    localparam int PERIOD_RST = 16'h00c8;
    localparam int DELAY_RST = 16'h0000;
    localparam int GAP_RST = 16'h0032;
    localparam int BBLEN_RST = 16'h0100;

    typedef enum logic [2:0] {SRC_SCALAR, SRC_AUTO, SRC_TRIG, SRC_GATE, SRC_DPULSE} ppt_src_e;
    typedef enum logic [1:0] {STY_CONT, STY_SINGLE, STY_GATE_HI, STY_GATE_LO} ppt_style_e;
    typedef enum logic [1:0] {BSRC_KEY, BSRC_EXT, BSRC_BUS} ppt_bbsrc_e;
    typedef enum logic [1:0] {PG_IDLE, PG_DELAY, PG_HIGH} ppt_pg_e;
    typedef enum logic {BB_IDLE, BB_PLAY} ppt_bb_e;
endpackage
`default_nettype wire

/* File: hdl/ppt_pulse_gen.sv */
`default_nettype none
module ppt_pulse_gen #(
    parameter int CW = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [CW-1:0] delay_i,
    input wire logic [CW-1:0] width_i,
    output logic pulse_o,
    output logic busy_o
);
    import ppt_pkg::*;

    typedef struct packed {
        ppt_pg_e st;
        logic [CW-1:0] cnt;
        logic pulse;
    } ppt_pg_s;

    ppt_pg_s r;
    ppt_pg_s n;

    always_comb begin
        n = r;
        case (r.st)
            PG_IDLE: begin
                // Retrigger while busy is ignored
                if (start_i) begin
                    if (delay_i == '0 && width_i != '0) begin // RQ12
                        n.st = PG_HIGH;
                        n.pulse = 1'b1;
                        n.cnt = width_i - CW'(1);
                    end else if (delay_i != '0) begin // RQ3
                        n.st = PG_DELAY;
                        n.cnt = delay_i - CW'(1);
                    end
                end
            end
            PG_DELAY: begin
                if (r.cnt != '0) begin
                    n.cnt = r.cnt - CW'(1);
                end else if (width_i != '0) begin // RQ12
                    n.st = PG_HIGH;
                    n.pulse = 1'b1;
                    n.cnt = width_i - CW'(1);
                end else begin
                    n.st = PG_IDLE;
                end
            end
            PG_HIGH: begin
                if (r.cnt != '0) begin
                    n.cnt = r.cnt - CW'(1);
                end else begin
                    n.st = PG_IDLE;
                    n.pulse = 1'b0;
                end
            end
            default: begin
                n.st = PG_IDLE;
                n.pulse = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '{st: PG_IDLE, cnt: '0, pulse: 1'b0};
        end else begin
            r <= n;
        end
    end

    assign pulse_o = r.pulse;
    assign busy_o = (r.st != PG_IDLE);

    zero_delay_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ12
        (r.st == PG_IDLE && start_i && delay_i == '0 && width_i != '0) |=> pulse_o)
        else $error("zero delay pulse did not start next cycle");
    delay_wait_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ3
        (r.st == PG_IDLE && start_i && delay_i == CW'(2) && width_i != '0) |=> !pulse_o ##1 !pulse_o ##1 pulse_o)
        else $error("delayed pulse came at wrong time");
endmodule
`default_nettype wire

/* File: hdl/ppt_trigger_top.sv */
// Function
// [RQ1] Scalar mode: fixed 18us high, 36us period
// [RQ2] Auto mode free-runs, ignores external input
// [RQ3] Triggered mode: leading edge starts delay, pulse
// [RQ4] Gated mode: internal pulse AND external input
// [RQ5] Below 1us width, software opens level loop
// [RQ6] Baseband styles continuous/single/gate; key/ext/bus sources
// [RQ7] Single style: each trigger edge plays one pass
// [RQ8] High gate: output active while input high
// [RQ9] Gate style forces external source, matching polarity
// [RQ10] Open gate plays passes continuously
// [RQ11] Low gate: output active while input low
// [RQ12] Triggered pulse uses width; delay off means zero
`default_nettype none
module ppt_trigger_top #(
    parameter int CW = 16,
    parameter int SCALAR_HIGH_CYC = ppt_pkg::SCALAR_HIGH_CYC,
    parameter int SCALAR_PERIOD_CYC = ppt_pkg::SCALAR_PERIOD_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [ppt_pkg::ADDR_W-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic ext_pulse_i,
    input wire logic ext_trig_i,
    input wire logic key_trig_i,
    output logic [31:0] rdata_o,
    output logic pm_gate_o,
    output logic bb_run_o,
    output logic bb_start_o
);
    import ppt_pkg::*;

    typedef struct packed {
        logic pm_en;
        ppt_src_e src;
        logic bb_en;
        ppt_style_e style;
        ppt_bbsrc_e bbsrc;
        logic pol;
        logic [CW-1:0] width;
        logic [CW-1:0] period;
        logic [CW-1:0] delay;
        logic [CW-1:0] gap;
        logic [CW-1:0] bb_len;
        logic [CW-1:0] per_cnt;
        logic [CW-1:0] bb_cnt;
        ppt_bb_e bb_st;
        logic bus_trig;
        logic pulse_prev;
        logic trig_prev;
        logic pm_out;
        logic bb_start;
        logic [15:0] passes;
        logic [31:0] rdata;
    } ppt_state_s;

    localparam logic [CW-1:0] SCAL_HI = CW'(SCALAR_HIGH_CYC);
    localparam logic [CW-1:0] SCAL_PER = CW'(SCALAR_PERIOD_CYC);
    localparam logic [CW-1:0] NARROW = CW'(NARROW_PW_CYC);

    localparam ppt_state_s RST_STATE = '{
        pm_en: 1'b0, src: SRC_SCALAR, bb_en: 1'b0, style: STY_CONT, bbsrc: BSRC_KEY, pol: 1'b0,
        width: CW'(WIDTH_RST), period: CW'(PERIOD_RST), delay: CW'(DELAY_RST), gap: CW'(GAP_RST),
        bb_len: CW'(BBLEN_RST), per_cnt: '0, bb_cnt: '0, bb_st: BB_IDLE, bus_trig: 1'b0,
        pulse_prev: 1'b0, trig_prev: 1'b0, pm_out: 1'b0, bb_start: 1'b0, passes: 16'h0000,
        rdata: 32'h0000_0000};

    ppt_state_s r;
    ppt_state_s n;

    logic [CW-1:0] per_lim;
    logic per_high;
    logic pulse_edge;
    logic pm_lvl;
    logic g0_start;
    logic g1_start;
    logic [CW-1:0] g0_delay;
    logic g0_pulse;
    logic g0_busy;
    logic g1_pulse;
    logic trig_lvl;
    logic trig_ev;
    logic gate_style;
    logic go_start;
    logic [CW-1:0] len_m1;
    logic narrow;
    ppt_style_e wr_style;

    ppt_pulse_gen #(.CW(CW)) u_gen_first (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(g0_start),
        .delay_i(g0_delay),
        .width_i(r.width),
        .pulse_o(g0_pulse),
        .busy_o(g0_busy)
    );

    // Second pulse of a double pulse, offset by the gap
    ppt_pulse_gen #(.CW(CW)) u_gen_second (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(g1_start),
        .delay_i(r.gap),
        .width_i(r.width),
        .pulse_o(g1_pulse),
        .busy_o()
    );

    always_comb begin
        n = r;
        n.bus_trig = 1'b0;
        n.bb_start = 1'b0;
        n.rdata = 32'h0000_0000;
        n.pulse_prev = ext_pulse_i;
        wr_style = ppt_style_e'(wdata_i[CTRL_STYLE_LSB +: 2]);

        // Pulse modulation: shared period counter
        per_lim = (r.src == SRC_SCALAR) ? SCAL_PER : r.period; // RQ1
        per_high = (r.src == SRC_SCALAR) ? (r.per_cnt < SCAL_HI) : (r.per_cnt < r.width); // RQ1
        if (per_lim <= CW'(1) || r.per_cnt >= per_lim - CW'(1)) begin
            n.per_cnt = '0;
        end else begin
            n.per_cnt = r.per_cnt + CW'(1);
        end
        pulse_edge = ext_pulse_i & ~r.pulse_prev;
        g0_start = r.pm_en & (((r.src == SRC_TRIG) & pulse_edge) // RQ3
            | ((r.src == SRC_DPULSE) & (r.per_cnt == '0)));
        g0_delay = (r.src == SRC_TRIG) ? r.delay : '0; // RQ12
        g1_start = r.pm_en & (r.src == SRC_DPULSE) & (r.per_cnt == '0);
        case (r.src)
            SRC_SCALAR: pm_lvl = per_high; // RQ1
            SRC_AUTO: pm_lvl = per_high; // RQ2
            SRC_TRIG: pm_lvl = g0_pulse; // RQ3
            SRC_GATE: pm_lvl = per_high & ext_pulse_i; // RQ4
            SRC_DPULSE: pm_lvl = g0_pulse | g1_pulse;
            default: pm_lvl = 1'b0;
        endcase
        n.pm_out = r.pm_en & pm_lvl;
        // Hint only; the level loop itself lives outside this block
        narrow = r.pm_en & (r.width < NARROW); // RQ5

        // Baseband trigger
        trig_lvl = ext_trig_i ^ r.pol;
        n.trig_prev = trig_lvl;
        case (r.bbsrc) // RQ6
            BSRC_KEY: trig_ev = key_trig_i;
            BSRC_EXT: trig_ev = trig_lvl & ~r.trig_prev; // RQ7
            BSRC_BUS: trig_ev = r.bus_trig;
            default: trig_ev = 1'b0;
        endcase
        gate_style = (r.style == STY_GATE_HI) || (r.style == STY_GATE_LO);
        len_m1 = (r.bb_len == '0) ? '0 : r.bb_len - CW'(1);
        go_start = r.bb_en & ((r.style == STY_CONT) | ((r.style == STY_SINGLE) & trig_ev) // RQ6 RQ7
            | (gate_style & trig_lvl)); // RQ8 RQ11
        case (r.bb_st)
            BB_IDLE: begin
                if (go_start) begin
                    n.bb_st = BB_PLAY;
                    n.bb_cnt = len_m1;
                    n.bb_start = 1'b1;
                end
            end
            BB_PLAY: begin
                // Triggers during a single pass are dropped
                if (!r.bb_en || (gate_style && !trig_lvl)) begin // RQ8 RQ11
                    n.bb_st = BB_IDLE;
                end else if (r.bb_cnt != '0) begin
                    n.bb_cnt = r.bb_cnt - CW'(1);
                end else if (r.style == STY_SINGLE) begin // RQ7
                    n.bb_st = BB_IDLE;
                end else begin // RQ10
                    n.bb_cnt = len_m1;
                    n.bb_start = 1'b1;
                end
            end
            default: n.bb_st = BB_IDLE;
        endcase
        if (n.bb_start) begin
            n.passes = r.passes + 16'h0001;
        end

        // Register writes
        if (wr_i) begin
            case (addr_i)
                REG_CTRL: begin
                    n.pm_en = wdata_i[CTRL_PM_EN];
                    n.src = ppt_src_e'(wdata_i[CTRL_SRC_LSB +: 3]);
                    n.bb_en = wdata_i[CTRL_BB_EN];
                    n.style = wr_style;
                    if (wr_style == STY_GATE_HI || wr_style == STY_GATE_LO) begin // RQ9
                        n.bbsrc = BSRC_EXT;
                        n.pol = (wr_style == STY_GATE_LO);
                    end else begin
                        n.bbsrc = ppt_bbsrc_e'(wdata_i[CTRL_BBSRC_LSB +: 2]);
                        n.pol = wdata_i[CTRL_POL];
                    end
                end
                REG_WIDTH: n.width = wdata_i[CW-1:0];
                REG_PERIOD: n.period = wdata_i[CW-1:0];
                REG_DELAY: n.delay = wdata_i[CW-1:0];
                REG_GAP: n.gap = wdata_i[CW-1:0];
                REG_BBLEN: n.bb_len = wdata_i[CW-1:0];
                REG_BBCMD: n.bus_trig = wdata_i[CMD_BUS_TRIG];
                default: ;
            endcase
        end

        // Register reads, data valid one cycle later only
        if (rd_i) begin
            case (addr_i)
                REG_CTRL: n.rdata = {22'h000000, r.pol, r.bbsrc, r.style, r.bb_en, r.src, r.pm_en};
                REG_WIDTH: n.rdata = 32'(r.width);
                REG_PERIOD: n.rdata = 32'(r.period);
                REG_DELAY: n.rdata = 32'(r.delay);
                REG_GAP: n.rdata = 32'(r.gap);
                REG_BBLEN: n.rdata = 32'(r.bb_len);
                REG_STATUS: n.rdata = {r.passes, 10'h000, narrow, r.pol, r.bbsrc, (r.bb_st == BB_PLAY), r.pm_out};
                default: n.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= RST_STATE;
        end else begin
            r <= n;
        end
    end

    assign rdata_o = r.rdata;
    assign pm_gate_o = r.pm_out;
    assign bb_run_o = (r.bb_st == BB_PLAY);
    assign bb_start_o = r.bb_start;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_trig_edge;
        r.pm_en && r.src == SRC_TRIG && pulse_edge && !g0_busy && r.delay == '0 && r.width != '0;
    endsequence
    sequence s_pulse_seen;
        g0_pulse ##1 pm_gate_o;
    endsequence

    scalar_level_a: assert property ((r.pm_en && r.src == SRC_SCALAR) // RQ1
        |=> pm_gate_o == ($past(r.per_cnt) < SCAL_HI))
        else $error("scalar pulse level wrong");
    scalar_period_a: assert property ((r.src == SRC_SCALAR && r.per_cnt == SCAL_PER - CW'(1)) // RQ1
        |=> r.per_cnt == '0)
        else $error("scalar period did not wrap");
    auto_free_a: assert property ((r.pm_en && r.src == SRC_AUTO) // RQ2
        |=> pm_gate_o == ($past(r.per_cnt) < $past(r.width)))
        else $error("auto pulse followed something other than its timer");
    trig_pulse_a: assert property (s_trig_edge |=> s_pulse_seen) // RQ3
        else $error("triggered pulse missing after edge");
    gate_and_a: assert property ((r.pm_en && r.src == SRC_GATE) // RQ4
        |=> pm_gate_o == ($past(ext_pulse_i) && ($past(r.per_cnt) < $past(r.width))))
        else $error("gated pulse is not the AND");
    single_start_a: assert property ((r.bb_en && r.style == STY_SINGLE && r.bb_st == BB_IDLE && trig_ev) // RQ7
        |=> bb_run_o && bb_start_o)
        else $error("single trigger did not start a pass");
    single_ignore_a: assert property ((r.bb_st == BB_PLAY && r.style == STY_SINGLE && r.bb_cnt != '0) // RQ7
        |=> !bb_start_o)
        else $error("retrigger during single pass");
    gate_high_a: assert property ((r.bb_en && r.style == STY_GATE_HI) // RQ8
        |=> bb_run_o == $past(ext_trig_i))
        else $error("high gate does not follow input");
    gate_low_a: assert property ((r.bb_en && r.style == STY_GATE_LO) // RQ11
        |=> bb_run_o == !$past(ext_trig_i))
        else $error("low gate does not follow input");
    gate_force_a: assert property (gate_style // RQ9
        |-> r.bbsrc == BSRC_EXT && r.pol == (r.style == STY_GATE_LO))
        else $error("gate style did not force source and polarity");
    gate_loop_a: assert property ((r.bb_en && gate_style && r.bb_st == BB_PLAY && r.bb_cnt == '0 && trig_lvl) // RQ10
        |=> bb_start_o && bb_run_o)
        else $error("open gate stopped after one pass");
endmodule
`default_nettype wire

/* File: bench/ppt_ext_src.sv */
`default_nettype none
module ppt_ext_src (
    input wire logic clk_i,
    output logic ext_pulse_o,
    output logic ext_trig_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        ext_pulse_o = 1'b0;
        ext_trig_o = 1'b0;
    end
    // Levels move on an edge through a nonblocking write, so logic sees them at the next edge
    task automatic put(input bit which, input bit v);
        @(posedge clk_i);
        if (which) begin
            ext_trig_o <= v;
        end else begin
            ext_pulse_o <= v;
        end
    endtask
endmodule
`default_nettype wire

/* File: bench/test_pulse_and_playback_trigger.sv */
`default_nettype none
module test_pulse_and_playback_trigger;
    timeunit 1ns;
    timeprecision 1ps;
    import ppt_pkg::*;
    localparam int SH = 4;
    localparam int SP = 8;
    logic clk_i, rst_i, wr_i, rd_i, key_trig_i, ext_pulse_i, ext_trig_i;
    logic [ADDR_W-1:0] addr_i;
    logic [31:0] wdata_i, rdata_o, rd;
    logic pm_gate_o, bb_run_o, bb_start_o;
    int n_fail = 0;
    int n_compared = 0;
    int cyc = 0;
    logic [31:0] lfsr = 32'h7edda381;
    bit q[$];
    logic [ADDR_W-1:0] ra[7] = '{REG_CTRL, REG_WIDTH, REG_PERIOD, REG_DELAY, REG_GAP, REG_BBLEN, 5'h02};
    int rv[7] = '{0, WIDTH_RST, PERIOD_RST, DELAY_RST, GAP_RST, BBLEN_RST, 0};

    ppt_trigger_top #(.SCALAR_HIGH_CYC(SH), .SCALAR_PERIOD_CYC(SP)) ppt_trigger_top_inst (
        .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .ext_pulse_i(ext_pulse_i), .ext_trig_i(ext_trig_i), .key_trig_i(key_trig_i), .rdata_o(rdata_o),
        .pm_gate_o(pm_gate_o), .bb_run_o(bb_run_o), .bb_start_o(bb_start_o));
    ppt_ext_src ppt_ext_src_inst (.clk_i(clk_i), .ext_pulse_o(ext_pulse_i), .ext_trig_o(ext_trig_i));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic complete_run();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            n_fail++;
            complete_run();
        end
    end

    task automatic cmp_bit(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input int d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= 32'(d);
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rdr(input logic [ADDR_W-1:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        rd = rdata_o;
    endtask

    // Step off the edge first so an output launched on it is not read mid-update
    task automatic wait_for(input bit bb, input logic v);
        #1;
        for (int i = 0; i < 200 && (bb ? bb_start_o : pm_gate_o) !== v; i++) begin
            @(posedge clk_i);
            #1;
        end
    endtask

    // Aligns on a full pulse first: enabling mid-period gives a short one
    task automatic run_pm(input int hi, input int per, input int n, input bit rnd, input bit gate);
        bit v, prev;
        prev = 1'b1;
        wait_for(1'b0, 1'b1);
        wait_for(1'b0, 1'b0);
        wait_for(1'b0, 1'b1);
        for (int i = 1; i <= n; i++) begin
            lfsr = nxt(lfsr);
            v = rnd ? lfsr[0] : 1'b1;
            ppt_ext_src_inst.put(1'b0, v);
            #1;
            cmp_bit("pm_gate", ((i % per) < hi) && (prev || !gate), pm_gate_o);
            prev = v;
        end
        ppt_ext_src_inst.put(1'b0, 1'b1);
    endtask

    // Second edge lands while the generator is busy and must be dropped
    task automatic trig_pm(input int d, input int w);
        wr(REG_DELAY, d);
        wr(REG_WIDTH, w);
        ppt_ext_src_inst.put(1'b0, 1'b0);
        repeat (2) @(posedge clk_i);
        ppt_ext_src_inst.put(1'b0, 1'b1);
        for (int k = 1; k <= d + w + 6; k++) begin
            ppt_ext_src_inst.put(1'b0, k == 2);
            #1;
            cmp_bit("pm_trig", k >= 2 + d && k <= 1 + d + w, pm_gate_o);
        end
    endtask

    task automatic bb_pass(input int src, input int len);
        wr(REG_CTRL, 32'h30 | (32'(src) << CTRL_BBSRC_LSB));
        wr(REG_BBLEN, len);
        repeat (3) @(posedge clk_i);
        if (src == 2) begin
            wr(REG_BBCMD, 1);
        end else begin
            ppt_ext_src_inst.put(1'b1, src == 1);
            key_trig_i <= src == 0;
        end
        for (int k = 1; k <= len + 5; k++) begin
            ppt_ext_src_inst.put(1'b1, src == 1 && k == 2);
            key_trig_i <= src == 0 && k == 2;
            #1;
            cmp_bit("bb_start", k == 1, bb_start_o);
            cmp_bit("bb_run", k >= 1 && k < 1 + len, bb_run_o);
        end
    endtask

    // Source and polarity written wrong on purpose; gate style overrides them
    task automatic bb_gate(input int sty);
        bit pol;
        pol = sty == 3;
        ppt_ext_src_inst.put(1'b1, pol);
        wr(REG_BBLEN, 2);
        wr(REG_CTRL, 32'h10 | (32'(sty) << CTRL_STYLE_LSB) | (32'(!pol) << CTRL_POL));
        rdr(REG_CTRL);
        cmp_word("ctrl", 32'h90 | (32'(sty) << CTRL_STYLE_LSB) | (32'(pol) << CTRL_POL), rd);
        q = {pol};
        for (int i = 0; i < 40; i++) begin
            q.push_back(((i % 13) < 8) ^ pol);
            ppt_ext_src_inst.put(1'b1, q[$]);
            #1;
            cmp_bit("bb_gate", q[0] ^ pol, bb_run_o);
            void'(q.pop_front());
        end
    endtask

    initial begin
        rst_i = 1'b1;
        wr_i = 1'b0;
        rd_i = 1'b0;
        key_trig_i = 1'b0;
        addr_i = '0;
        wdata_i = '0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            rdr(ra[i]);
            cmp_word("reset_value", 32'(rv[i]), rd);
        end
        @(posedge clk_i);
        #1;
        cmp_word("rdata_idle", 32'h0, rdata_o);
        $display("test registers done");
        wr(REG_CTRL, 32'h1);
        run_pm(SH, SP, 24, 1'b0, 1'b0);
        wr(REG_WIDTH, 3);
        wr(REG_PERIOD, 7);
        wr(REG_CTRL, 32'h3);
        run_pm(3, 7, 30, 1'b1, 1'b0);
        wr(REG_CTRL, 32'h7);
        run_pm(3, 7, 40, 1'b1, 1'b1);
        $display("test pulse modes done");
        wr(REG_CTRL, 32'h5);
        trig_pm(0, 3);
        trig_pm(5, 3);
        trig_pm(2, 3);
        rdr(REG_STATUS);
        cmp_bit("narrow_hint", 1'b1, rd[5]);
        wr(REG_GAP, 3);
        wr(REG_PERIOD, 12);
        wr(REG_CTRL, 32'h9);
        // Pulses at 1..3 and, after the gap, 4..6 merge into one 6 of 12
        run_pm(6, 12, 36, 1'b1, 1'b0);
        $display("test triggered pulse done");
        for (int s = 1; s < 4; s++) begin
            bb_pass(s % 3, 3);
        end
        $display("test single pass done");
        bb_gate(2);
        bb_gate(3);
        $display("test gate styles done");
        wr(REG_BBLEN, 3);
        wr(REG_CTRL, 32'h10);
        wait_for(1'b1, 1'b1);
        for (int k = 1; k <= 9; k++) begin
            @(posedge clk_i);
            #1;
            cmp_bit("bb_cont_start", k % 3 == 0, bb_start_o);
            cmp_bit("bb_cont_run", 1'b1, bb_run_o);
        end
        $display("test continuous done");
        complete_run();
    end
endmodule
`default_nettype wire
